// ==== common/ajb_map.svh ====
/*
 * Constants of the angle jump block and event logger: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 125 MHz system clock and a one-cycle register port.
 */
// Summary of operation
// - Block input sampled once per processing cycle, used for the whole cycle.
// - Pick-up with block inactive raises trip or alarm and runs operate timing.
// - Pick-up with block active raises only blocked, nothing further.
// - Entering blocked gives display notice and event with voltages and fault type.
// - ON and OFF events on block, trip, alarm changes, one per clock by priority, others in that clock lost; setting selects stored kinds.
// - Every event carries a time stamp and current process data.
// - Twelve most recent operation records kept, each time-stamped.
// - Record holds ON event, time, name, fault phase, angle differences, group.
// - Three angle differences against 20 ms ago, 0.01 degree steps.
// - Condition code: 0 normal, 1 blocked, 2 trip, 3 alarm.
// - Channel selection validity: 0 valid, 1 not available.
// - Node behaviour code: 1 on, 2 blocked, 3 test, 4 test/blocked, 5 off.
// - Three voltage to undervoltage limit ratios, 0.01 per-unit.
// - Trip stays active 20 ms then clears by itself.
// - Measured voltage below undervoltage limit counts as blocked.
`ifndef AJB_MAP_SVH
`define AJB_MAP_SVH

// Register offsets (byte addresses)
`define AJB_REG_CTRL 8'h00
`define AJB_REG_LIMIT 8'h04
`define AJB_REG_STATUS 8'h08
`define AJB_REG_IRQ_STAT 8'h0c
`define AJB_REG_IRQ_EN 8'h10
`define AJB_REG_IRQ_CLR 8'h14
`define AJB_REG_ANG0 8'h18
`define AJB_REG_ANG1 8'h1c
`define AJB_REG_ANG2 8'h20
`define AJB_REG_RAT0 8'h24
`define AJB_REG_RAT1 8'h28
`define AJB_REG_RAT2 8'h2c
`define AJB_REG_EVT_CNT 8'h30
`define AJB_REG_REC_SEL 8'h34
`define AJB_REG_REC_TIME 8'h38
`define AJB_REG_REC_INFO 8'h3c
`define AJB_REG_REC_ANG 8'h40
`define AJB_REG_TIME 8'h44

// Control field positions
`define AJB_CTRL_MODE_LSB 0
`define AJB_CTRL_EVSEL_LSB 4
`define AJB_CTRL_ALARM_EN_BIT 6
`define AJB_CTRL_MON_LSB 8
`define AJB_CTRL_SG_LSB 12
`define AJB_CTRL_RESET 32'h0000_0101

// Interrupt bits
`define AJB_IRQ_BLOCK 0
`define AJB_IRQ_TRIP 1
`define AJB_IRQ_ALARM 2
`define AJB_IRQ_REC 3

// Timing
`define AJB_CLK_MHZ 125
`define AJB_CYCLE_US 5000
`define AJB_TRIP_HOLD_US 20000
`define AJB_MS_CYCLES (1000 * `AJB_CLK_MHZ)
`define AJB_CYCLE_CYCLES (`AJB_CYCLE_US * `AJB_CLK_MHZ)
`define AJB_TRIP_HOLD_CYCLES (`AJB_TRIP_HOLD_US * `AJB_CLK_MHZ)

`define AJB_RECORDS 12

`endif

// ==== common/ajb_pkg.sv ====
/*
 * Types of the angle jump block: condition and behaviour codes, events.
 * Assumes the constants header is included alongside.
 */
package ajb_pkg;

    typedef enum logic [1:0]
    {
        AJB_COND_NORMAL = 2'h0,
        AJB_COND_BLOCKED = 2'h1,
        AJB_COND_TRIP = 2'h2,
        AJB_COND_ALARM = 2'h3
    } ajb_cond_t;

    typedef enum logic [2:0]
    {
        AJB_BEH_ON = 3'h1,
        AJB_BEH_BLOCKED = 3'h2,
        AJB_BEH_TEST = 3'h3,
        AJB_BEH_TEST_BLOCKED = 3'h4,
        AJB_BEH_OFF = 3'h5
    } ajb_beh_t;

    typedef enum logic [2:0]
    {
        AJB_EV_BLOCK_ON = 3'h0,
        AJB_EV_BLOCK_OFF = 3'h1,
        AJB_EV_TRIP_ON = 3'h2,
        AJB_EV_TRIP_OFF = 3'h3,
        AJB_EV_ALARM_ON = 3'h4,
        AJB_EV_ALARM_OFF = 3'h5
    } ajb_ev_t;

    typedef struct packed
    {
        logic [31:0] stamp_ms;
        ajb_ev_t name;
        logic [1:0] fault;
        logic [2:0] sg;
        logic [15:0] trip_ang;
        logic [15:0] alarm_ang;
    } ajb_rec_t;

endpackage

// ==== common/ajb_rec_if.sv ====
/*
 * Interface between the logger core and its record store.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/10ps
interface ajb_rec_if;
    import ajb_pkg::*;
    logic wr;
    ajb_rec_t wdata;
    logic [3:0] rd_idx;
    ajb_rec_t rdata;
    logic [3:0] count;

    modport core (output wr, output wdata, output rd_idx, input rdata, input count);
    modport store (input wr, input wdata, input rd_idx, output rdata, output count);
endinterface

// ==== hdl/ajb_rec_store.sv ====
/*
 * Ring store of the newest operation records.
 * Assumes one write strobe per record from the logger core.
 */
`timescale 1ns/10ps
`include "ajb_map.svh"
module ajb_rec_store
    import ajb_pkg::*;
#(
    parameter int DEPTH = `AJB_RECORDS
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    ajb_rec_if.store rec
);
    if (DEPTH < 2 || DEPTH > 15)
    begin : g_depth_chk
        $error("ajb_rec_store: DEPTH out of range");
    end

    ajb_rec_t mem_ff [DEPTH];
    logic [3:0] wptr_ff;
    logic [3:0] count_ff;
    wire logic wrap = (wptr_ff == 4'(DEPTH - 1));
    wire logic [3:0] nxt_wptr = wrap ? 4'h0 : wptr_ff + 4'h1;
    // Index 0 is newest, older ones behind it
    wire logic [3:0] back = (wptr_ff > rec.rd_idx) ? wptr_ff - rec.rd_idx - 4'h1
                            : 4'(DEPTH) + wptr_ff - rec.rd_idx - 4'h1;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wptr_ff <= 4'h0;
            count_ff <= 4'h0;
        end
        else if (rec.wr)
        begin
            wptr_ff <= nxt_wptr;
            if (count_ff != 4'(DEPTH))
                count_ff <= count_ff + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rec.wr)
            mem_ff[wptr_ff] <= rec.wdata;
    end

    assign rec.count = count_ff;
    assign rec.rdata = (rec.rd_idx < count_ff) ? mem_ff[back] : '0;

    a_count_saturates: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        count_ff <= 4'(DEPTH)) else $error("record count above depth");
    a_ring_wraps: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rec.wr && wrap |=> wptr_ff == 4'h0) else $error("record pointer failed to wrap");
endmodule // ajb_rec_store

// ==== hdl/ajb_cycle_tick.sv ====
/*
 * Divider making one-cycle processing and millisecond enables.
 * Assumes the 125 MHz system clock.
 */
`timescale 1ns/10ps
`include "ajb_map.svh"
module ajb_cycle_tick
#(
    parameter int CYCLE_CNT = `AJB_CYCLE_CYCLES,
    parameter int MS_CNT = `AJB_MS_CYCLES
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    output logic cycle_tick_o,
    output logic ms_tick_o
);
    // Counter widths limit the counts
    if (CYCLE_CNT < 2 || CYCLE_CNT > 1048576 || MS_CNT < 2 || MS_CNT > 131072)
    begin : g_cnt_chk
        $error("ajb_cycle_tick: counts out of range");
    end

    logic [19:0] cyc_ff;
    logic [16:0] ms_ff;
    wire logic cyc_end = (cyc_ff == 20'(CYCLE_CNT - 1));
    wire logic ms_end = (ms_ff == 17'(MS_CNT - 1));

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cyc_ff <= 20'h0;
            ms_ff <= 17'h0;
            cycle_tick_o <= 1'b0;
            ms_tick_o <= 1'b0;
        end
        else
        begin
            cyc_ff <= cyc_end ? 20'h0 : cyc_ff + 20'h1;
            ms_ff <= ms_end ? 17'h0 : ms_ff + 17'h1;
            cycle_tick_o <= cyc_end;
            ms_tick_o <= ms_end;
        end
    end
endmodule // ajb_cycle_tick

// ==== hdl/ajb_logger.sv ====
/*
 * Angle jump block: blocking, status, events and operation records.
 * Assumes pick-up, voltages and angles arrive from logic on the same clock;
 * the block input is a pin and is synchronised here.
 */
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "ajb_map.svh"
module ajb_logger
    import ajb_pkg::*;
#(
    parameter int CYCLE_CNT = `AJB_CYCLE_CYCLES,
    parameter int MS_CNT = `AJB_MS_CYCLES,
    parameter int TRIP_HOLD = `AJB_TRIP_HOLD_CYCLES
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic block_i,
    input wire logic trip_pickup_i,
    input wire logic alarm_pickup_i,
    input wire logic [1:0] fault_i,
    input wire logic [2:0] chan_avail_i,
    input wire logic chan_u4_avail_i,
    input wire logic [15:0] volt0_i,
    input wire logic [15:0] volt1_i,
    input wire logic [15:0] volt2_i,
    input wire logic [15:0] ang0_i,
    input wire logic [15:0] ang1_i,
    input wire logic [15:0] ang2_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic trip_o,
    output logic alarm_o,
    output logic blocked_o,
    output logic hmi_note_o,
    output logic ev_valid_o,
    output logic [2:0] ev_name_o,
    output logic [31:0] ev_stamp_o,
    output logic [63:0] ev_data_o,
    output logic irq_o
);
    if (TRIP_HOLD < 8 || TRIP_HOLD > 4194303)
    begin : g_hold_chk
        $error("ajb_logger: TRIP_HOLD out of range");
    end

    // ******************************
    // Synchroniser and ticks
    // ******************************
    logic blk_s1_ff;
    logic blk_s2_ff;
    logic cycle_tick;
    logic ms_tick;
    logic [31:0] time_ms_ff;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            blk_s1_ff <= 1'b0;
            blk_s2_ff <= 1'b0;
            time_ms_ff <= 32'h0;
        end
        else
        begin
            blk_s1_ff <= block_i;
            blk_s2_ff <= blk_s1_ff;
            if (ms_tick)
                time_ms_ff <= time_ms_ff + 32'h1;
        end
    end

    ajb_cycle_tick #(.CYCLE_CNT(CYCLE_CNT), .MS_CNT(MS_CNT)) u_tick
    (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .cycle_tick_o(cycle_tick),
        .ms_tick_o(ms_tick)
    );

    // ******************************
    // Control registers
    // ******************************
    logic [31:0] ctrl_ff;
    logic [15:0] limit_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_en_ff;
    logic [3:0] rec_sel_ff;
    logic [15:0] evt_cnt_ff;

    wire logic [2:0] mode = ctrl_ff[`AJB_CTRL_MODE_LSB +: 3];
    wire logic [1:0] ev_sel = ctrl_ff[`AJB_CTRL_EVSEL_LSB +: 2];
    wire logic alarm_en = ctrl_ff[`AJB_CTRL_ALARM_EN_BIT];
    wire logic [3:0] mon_sel = ctrl_ff[`AJB_CTRL_MON_LSB +: 4];
    wire logic [2:0] sg_idx = ctrl_ff[`AJB_CTRL_SG_LSB +: 3];
    wire logic wr_ctrl = wr_i && addr_i == `AJB_REG_CTRL;
    wire logic wr_limit = wr_i && addr_i == `AJB_REG_LIMIT;
    wire logic wr_en = wr_i && addr_i == `AJB_REG_IRQ_EN;
    wire logic wr_clr = wr_i && addr_i == `AJB_REG_IRQ_CLR;
    wire logic wr_sel = wr_i && addr_i == `AJB_REG_REC_SEL;

    // ******************************
    // Channel validity and undervoltage
    // ******************************
    // selection validity
    wire logic sel_ok = (mon_sel <= 4'h9) ? (&chan_avail_i)
                        : (mon_sel == 4'ha) ? chan_u4_avail_i : 1'b0;
    wire logic under_v = (volt0_i < limit_ff) || (volt1_i < limit_ff) || (volt2_i < limit_ff);
    wire logic mode_blk = (mode == AJB_BEH_BLOCKED) || (mode == AJB_BEH_TEST_BLOCKED);
    wire logic mode_off = (mode == AJB_BEH_OFF);

    // ******************************
    // Block sampling and outputs
    // ******************************
    logic blk_smp_ff;
    logic [21:0] hold_ff;
    wire logic blk_now = cycle_tick ? (blk_s2_ff || under_v || mode_blk) : blk_smp_ff;
    wire logic any_pick = (trip_pickup_i || (alarm_pickup_i && alarm_en)) && !mode_off;
    wire logic nxt_blocked = cycle_tick ? (any_pick && blk_now) : blocked_o;
    wire logic trip_start = cycle_tick && trip_pickup_i && !blk_now && !mode_off && !trip_o;
    wire logic nxt_alarm = cycle_tick ? (alarm_pickup_i && alarm_en && !blk_now && !mode_off)
                           : alarm_o;
    wire logic hold_end = trip_o && hold_ff == 22'(TRIP_HOLD - 1);

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            blk_smp_ff <= 1'b0;
            blocked_o <= 1'b0;
            alarm_o <= 1'b0;
            trip_o <= 1'b0;
            hold_ff <= 22'h0;
        end
        else
        begin
            blk_smp_ff <= blk_now;
            blocked_o <= nxt_blocked;
            alarm_o <= nxt_alarm;
            if (trip_start)
                trip_o <= 1'b1;
            else if (hold_end)
                trip_o <= 1'b0;
            hold_ff <= trip_o && !hold_end ? hold_ff + 22'h1 : 22'h0;
        end
    end

    // ******************************
    // Events
    // ******************************
    wire logic blk_on = nxt_blocked && !blocked_o;
    wire logic blk_off = !nxt_blocked && blocked_o;
    wire logic al_on = nxt_alarm && !alarm_o;
    wire logic al_off = !nxt_alarm && alarm_o;
    wire logic tr_off = hold_end;
    // Priority when several change together; one event per cycle
    wire logic [2:0] ev_pick = blk_on ? AJB_EV_BLOCK_ON : trip_start ? AJB_EV_TRIP_ON
                               : al_on ? AJB_EV_ALARM_ON : blk_off ? AJB_EV_BLOCK_OFF
                               : tr_off ? AJB_EV_TRIP_OFF : AJB_EV_ALARM_OFF;
    wire logic ev_any = blk_on || trip_start || al_on || blk_off || tr_off || al_off;
    wire logic ev_is_on = !ev_pick[0];
    wire logic ev_keep = ev_any && (ev_is_on ? ev_sel[0] : ev_sel[1]);

    ajb_rec_if rec();
    assign rec.wr = ev_any && ev_is_on;
    assign rec.wdata = '{stamp_ms: time_ms_ff, name: ajb_ev_t'(ev_pick), fault: fault_i,
                         sg: sg_idx, trip_ang: ang0_i, alarm_ang: ang1_i};
    assign rec.rd_idx = rec_sel_ff;

    ajb_rec_store #(.DEPTH(`AJB_RECORDS)) u_store
    (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .rec(rec)
    );

    wire logic [3:0] irq_set = {rec.wr, al_on, trip_start, blk_on};

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ev_valid_o <= 1'b0;
            ev_name_o <= 3'h0;
            ev_stamp_o <= 32'h0;
            ev_data_o <= 64'h0;
            hmi_note_o <= 1'b0;
            evt_cnt_ff <= 16'h0;
        end
        else
        begin
            ev_valid_o <= ev_keep;
            hmi_note_o <= blk_on;
            if (ev_keep)
            begin
                ev_name_o <= ev_pick;
                ev_stamp_o <= time_ms_ff;
                ev_data_o <= blk_on ? {14'h0, fault_i, volt2_i, volt1_i, volt0_i}
                             : {ang2_i, ang1_i, ang0_i, 14'h0, fault_i};
                evt_cnt_ff <= evt_cnt_ff + 16'h1;
            end
        end
    end

    // ******************************
    // Register port
    // ******************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_ff <= `AJB_CTRL_RESET;
            limit_ff <= 16'h0;
            irq_en_ff <= 4'h0;
            irq_stat_ff <= 4'h0;
            rec_sel_ff <= 4'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= wdata_i;
            if (wr_limit)
                limit_ff <= wdata_i[15:0];
            if (wr_en)
                irq_en_ff <= wdata_i[3:0];
            if (wr_sel)
                rec_sel_ff <= wdata_i[3:0];
            // Set beats clear
            irq_stat_ff <= (irq_stat_ff & ~(wr_clr ? wdata_i[3:0] : 4'h0)) | irq_set;
            irq_o <= |(irq_stat_ff & irq_en_ff);
        end
    end

    wire logic [1:0] cond = blocked_o ? AJB_COND_BLOCKED : trip_o ? AJB_COND_TRIP
                            : alarm_o ? AJB_COND_ALARM : AJB_COND_NORMAL;
    wire logic [2:0] beh = mode;
    wire logic [15:0] rat0 = limit_ff == 16'h0 ? 16'hffff : 16'((32'(volt0_i) * 100) / limit_ff);
    wire logic [15:0] rat1 = limit_ff == 16'h0 ? 16'hffff : 16'((32'(volt1_i) * 100) / limit_ff);
    wire logic [15:0] rat2 = limit_ff == 16'h0 ? 16'hffff : 16'((32'(volt2_i) * 100) / limit_ff);
    wire logic [31:0] rd_mux =
        addr_i == `AJB_REG_CTRL ? ctrl_ff :
        addr_i == `AJB_REG_LIMIT ? {16'h0, limit_ff} :
        addr_i == `AJB_REG_STATUS ? {24'h0, !sel_ok, beh, 2'h0, cond} :
        addr_i == `AJB_REG_IRQ_STAT ? {28'h0, irq_stat_ff} :
        addr_i == `AJB_REG_IRQ_EN ? {28'h0, irq_en_ff} :
        addr_i == `AJB_REG_ANG0 ? {{16{ang0_i[15]}}, ang0_i} :
        addr_i == `AJB_REG_ANG1 ? {{16{ang1_i[15]}}, ang1_i} :
        addr_i == `AJB_REG_ANG2 ? {{16{ang2_i[15]}}, ang2_i} :
        addr_i == `AJB_REG_RAT0 ? {16'h0, rat0} :
        addr_i == `AJB_REG_RAT1 ? {16'h0, rat1} :
        addr_i == `AJB_REG_RAT2 ? {16'h0, rat2} :
        addr_i == `AJB_REG_EVT_CNT ? {12'h0, rec.count, evt_cnt_ff} :
        addr_i == `AJB_REG_REC_SEL ? {28'h0, rec_sel_ff} :
        addr_i == `AJB_REG_REC_TIME ? rec.rdata.stamp_ms :
        addr_i == `AJB_REG_REC_INFO ? {24'h0, rec.rdata.sg, rec.rdata.fault, rec.rdata.name} :
        addr_i == `AJB_REG_REC_ANG ? {rec.rdata.alarm_ang, rec.rdata.trip_ang} :
        addr_i == `AJB_REG_TIME ? time_ms_ff : 32'h0;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 32'h0;
        else if (rd_i)
            rdata_o <= rd_mux;
        else
            rdata_o <= 32'h0;
    end

    // ******************************
    // Checks
    // ******************************
    sequence s_trip_rise;
        !trip_o ##1 trip_o;
    endsequence
    sequence s_trip_fall;
        trip_o ##1 !trip_o;
    endsequence

    a_trip_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_trip_rise |-> trip_o [*8]) else $error("trip dropped early");

    a_trip_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_trip_fall |-> $past(hold_ff) == 22'(TRIP_HOLD - 1)) else $error("trip length wrong");

    a_blocked_no_trip: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cycle_tick && blk_now |=> !$rose(trip_o)) else $error("trip while blocked");

    a_blocked_no_alarm: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cycle_tick && blk_now |=> !$rose(alarm_o)) else $error("alarm while blocked");

    a_pick_trips: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        trip_start |=> trip_o) else $error("trip not raised");

    a_block_note: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(blocked_o) |-> hmi_note_o) else $error("no display note on block");

    a_block_event: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        blk_on && ev_sel[0] |=> ev_valid_o && ev_name_o == 3'h0
        && ev_data_o[15:0] == $past(volt0_i)) else $error("block event wrong");

    a_event_filter: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ev_valid_o |-> (ev_name_o[0] ? ev_sel[1] : ev_sel[0]) || $past(wr_ctrl))
        else $error("event kind not selected");

    a_stamp_time: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ev_valid_o && !$past(ms_tick) |-> ev_stamp_o == time_ms_ff)
        else $error("event stamp wrong");

    a_record_stamp: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rec.wr && rec_sel_ff == 4'h0 && !wr_sel |=> rec.rdata.stamp_ms == $past(time_ms_ff))
        else $error("record stamp wrong");

    a_sample_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !cycle_tick |=> blk_smp_ff == $past(blk_smp_ff)) else $error("block resampled");

    a_cond_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        blocked_o |-> cond == 2'h1) else $error("condition code wrong");

    a_off_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cycle_tick && mode_off |=> !$rose(trip_o) && !$rose(alarm_o))
        else $error("output while off");

    a_undervolt_blk: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cycle_tick && under_v && any_pick |=> blocked_o) else $error("undervoltage not blocking");
endmodule // ajb_logger

// ==== sim/ajb_partner.sv ====
/* Blocking matrix and event buffer model beside the logger.
   Assumes the logger clock and registered event outputs. */
`timescale 1ns/10ps
module ajb_partner
(
    input wire logic sys_clk_i,
    input wire logic blk_req_i,
    input wire logic ev_valid_i,
    input wire logic [2:0] ev_name_i,
    input wire logic [63:0] ev_data_i,
    input wire logic hmi_i,
    output logic block_o
);
    int cnt [8];
    int n_hmi = 0;
    logic [63:0] last_data = 64'h0;
    initial
    begin
        block_o = 1'b0;
        forever @(posedge sys_clk_i) block_o <= blk_req_i;
    end
    always @(posedge sys_clk_i)
    begin
        if (ev_valid_i === 1'b1)
        begin
            cnt[ev_name_i] <= cnt[ev_name_i] + 1;
            last_data <= ev_data_i;
        end
        if (hmi_i === 1'b1)
            n_hmi <= n_hmi + 1;
    end
endmodule // ajb_partner

// ==== sim/angle_jump_block_event_logger_test.sv ====
/* Self-checking bench of the angle jump logger.
   Assumes shortened tick, millisecond and trip hold counts. */
`timescale 1ns/10ps
`include "ajb_map.svh"
module angle_jump_block_event_logger_test;
    import ajb_pkg::*;
    localparam int CY = 20;
    localparam int TH = 50;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, blk_req = 1'b0, block_i;
    logic trip_pickup_i = 1'b0, alarm_pickup_i = 1'b0, chan_u4_avail_i = 1'b1;
    logic [1:0] fault_i = 2'h2;
    logic [2:0] chan_avail_i = 3'h7, ev_name_o;
    logic [15:0] volt0_i = 16'h00c8, volt1_i = 16'h00c8, volt2_i = 16'h00c8;
    logic [15:0] ang0_i = 16'h8ca0, ang1_i = 16'h01f4, ang2_i = 16'h0000;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, rv, ev_stamp_o;
    logic [63:0] ev_data_o;
    logic wr_i = 1'b0, rd_i = 1'b0, trip_o, alarm_o, blocked_o, hmi_note_o, ev_valid_o, irq_o;
    int n_errors = 0, checks = 0, cyc = 0, n;

    ajb_logger #(.CYCLE_CNT(CY), .MS_CNT(5), .TRIP_HOLD(TH)) DUT (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .block_i(block_i),
        .trip_pickup_i(trip_pickup_i), .alarm_pickup_i(alarm_pickup_i), .fault_i(fault_i),
        .chan_avail_i(chan_avail_i), .chan_u4_avail_i(chan_u4_avail_i), .volt0_i(volt0_i),
        .volt1_i(volt1_i), .volt2_i(volt2_i), .ang0_i(ang0_i), .ang1_i(ang1_i),
        .ang2_i(ang2_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .trip_o(trip_o), .alarm_o(alarm_o), .blocked_o(blocked_o),
        .hmi_note_o(hmi_note_o), .ev_valid_o(ev_valid_o), .ev_name_o(ev_name_o),
        .ev_stamp_o(ev_stamp_o), .ev_data_o(ev_data_o), .irq_o(irq_o));
    ajb_partner partner (.sys_clk_i(sys_clk_i), .blk_req_i(blk_req), .ev_valid_i(ev_valid_o),
        .ev_name_i(ev_name_o), .ev_data_i(ev_data_o), .hmi_i(hmi_note_o), .block_o(block_i));

    // ****************
    // Clock and guard
    // ****************
    initial
    begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            stop_test;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        if (seen !== exp)
            n_errors++;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        rv = rdata_o;
    endtask
    task step(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask
    task trip_once(output int held);
        @(posedge sys_clk_i);
        trip_pickup_i <= 1'b1;
        for (held = 0; held < 100 && trip_o !== 1'b1; held++) step(1);
        for (held = 0; held < 200 && trip_o === 1'b1; held++)
        begin
            step(1);
            trip_pickup_i <= 1'b0;
        end
        step(2 * CY);
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_reset;
        rd(`AJB_REG_CTRL);
        chk(rv, 32'h0000_0101);
        rd(`AJB_REG_STATUS);
        chk(rv, 32'h0000_0010);
        rd(8'hfc);
        chk(rv, 32'h0);
        $display("reset test done");
    endtask
    task t_status;
        wr(`AJB_REG_LIMIT, 32'h0000_0064);
        step(3 * CY);
        rd(`AJB_REG_RAT0);
        chk(rv, 32'h0000_00c8);
        rd(`AJB_REG_ANG0);
        chk(rv, 32'hffff_8ca0);
        rd(`AJB_REG_ANG1);
        chk(rv, 32'h0000_01f4);
        chan_avail_i <= 3'h0;
        chan_u4_avail_i <= 1'b0;
        step(3 * CY);
        rd(`AJB_REG_STATUS);
        chk({31'h0, rv[7]}, 32'h1);
        chan_avail_i <= 3'h7;
        chan_u4_avail_i <= 1'b1;
        for (int m = 1; m <= 5; m++)
        begin
            wr(`AJB_REG_CTRL, 32'h0000_0100 | m);
            step(2 * CY);
            rd(`AJB_REG_STATUS);
            chk({29'h0, rv[6:4]}, m);
        end
        wr(`AJB_REG_CTRL, 32'h0000_0111);
        step(3 * CY);
        $display("status test done");
    endtask
    task t_trip;
        wr(`AJB_REG_IRQ_EN, 32'h2);
        trip_once(n);
        chk(n, TH);
        chk(partner.cnt[2], 1);
        chk(partner.cnt[3], 0);
        chk(partner.last_data[31:0], 32'h8ca0_0002);
        rd(`AJB_REG_REC_TIME);
        chk(ev_stamp_o, rv);
        chk(irq_o, 1'b1);
        wr(`AJB_REG_IRQ_CLR, 32'h2);
        step(2);
        chk(irq_o, 1'b0);
        wr(`AJB_REG_CTRL, 32'h0000_0131);
        trip_once(n);
        chk(partner.cnt[3], 1);
        $display("trip test done");
    endtask
    task t_block(input logic uv);
        @(posedge sys_clk_i);
        blk_req <= ~uv;
        volt0_i <= uv ? 16'h0032 : 16'h00c8;
        volt1_i <= uv ? 16'h0032 : 16'h00c8;
        volt2_i <= uv ? 16'h0032 : 16'h00c8;
        step(3 * CY);
        trip_pickup_i <= 1'b1;
        for (n = 0; n < 100 && blocked_o !== 1'b1; n++) step(1);
        step(3);
        chk(blocked_o, 1'b1);
        chk(trip_o, 1'b0);
        rd(`AJB_REG_STATUS);
        chk(rv[1:0], 2'h1);
        chk(partner.last_data[63:48], 16'h0002);
        chk(partner.n_hmi, uv ? 2 : 1);
        chk(partner.last_data[15:0], uv ? 16'h0032 : 16'h00c8);
        @(posedge sys_clk_i);
        trip_pickup_i <= 1'b0;
        blk_req <= 1'b0;
        volt0_i <= 16'h00c8;
        volt1_i <= 16'h00c8;
        volt2_i <= 16'h00c8;
        step(4 * CY);
        $display("block test done");
    endtask
    task t_alarm;
        wr(`AJB_REG_CTRL, 32'h0000_0171);
        @(posedge sys_clk_i);
        alarm_pickup_i <= 1'b1;
        for (n = 0; n < 100 && alarm_o !== 1'b1; n++) step(1);
        rd(`AJB_REG_STATUS);
        chk(rv[1:0], 2'h3);
        chk(trip_o, 1'b0);
        alarm_pickup_i <= 1'b0;
        step(4 * CY);
        chk(partner.cnt[4], 1);
        $display("alarm test done");
    endtask
    task t_rec;
        for (int i = 0; i < 13; i++) trip_once(n);
        rd(`AJB_REG_EVT_CNT);
        chk(rv[19:16], 4'hc);
        wr(`AJB_REG_REC_SEL, 32'h0);
        rd(`AJB_REG_REC_INFO);
        chk(rv[4:0], 5'h12);
        rd(`AJB_REG_REC_ANG);
        chk(rv, 32'h01f4_8ca0);
        $display("record test done");
    endtask

    task stop_test;
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        step(1);
        t_reset;
        t_status;
        t_trip;
        t_block(1'b0);
        t_block(1'b1);
        t_alarm;
        t_rec;
        stop_test;
    end
endmodule // angle_jump_block_event_logger_test
